/* File: flash_prog_consts.vh */
// Register indices, field codes and timing constants of the flash programming controller.
`ifndef FLASH_PROG_CONSTS_VH
`define FLASH_PROG_CONSTS_VH
// Register indices; the bus byte address is four times the index.
`define IDX_OP_SELECT   10'h0F2
`define IDX_KEY_SECOND  10'h0F3
`define IDX_KEY_THIRD   10'h0F4
`define IDX_KEY_FOURTH  10'h0F5
`define IDX_KEY_FIFTH   10'h0F6
`define IDX_PAGE_SELECT 10'h0F7
`define IDX_OFFSET_LOW  10'h0FB
`define IDX_PROG_BYTE   10'h0FC
`define IDX_ACCESS_CTRL 10'h0A7
`define IDX_STATUS      10'h0E0
// Reset value of every register.
`define REG_RESET       8'h00
// Operation select codes.
`define OP_SECTOR_ERASE 8'hE6
`define OP_BYTE_PROGRAM 8'h6E
// Unlock key values.
`define KEY_SECOND_VAL  4'h5
`define KEY_THIRD_VAL   4'hA
`define KEY_FOURTH_VAL  4'h9
`define KEY_FIFTH_VAL   4'h6
// Status register bit positions.
`define ST_BUSY         0
`define ST_ABORT        1
`define ST_REFUSED      2
`define ST_DONE         3
`define ST_PGM_MODE     4
// Programmer frame commands.
`define CMD_SECTOR_ERASE 8'h01
`define CMD_BYTE_PROGRAM 8'h02
`define CMD_BYTE_READ    8'h03
`define CMD_CHIP_ERASE   8'h04
`define CMD_BLOCK_ERASE  8'h05
`define CMD_EXIT         8'h0F
// Programmer frame and entry lengths.
`define FRAME_BITS      32
`define ENTRY_BITS      16
`define ENTRY_KEY_DFLT  16'hA5C3
// Timing: clock rate in kHz, erase time in ms, program time in us.
`define CLK_KHZ         25000
`define T_ERASE_MS      3
`define T_PROG_US       30
`define ERASE_CYC_DFLT  (`T_ERASE_MS * `CLK_KHZ)
`define PROG_CYC        (`T_PROG_US * `CLK_KHZ / 1000)
`endif

/* File: flash_self_program_control.v */
// Flash erase and program sequencer with bus registers and programmer entry.
//
// Register access over AHB-Lite was decided locally.
`include "flash_prog_consts.vh"
`default_nettype none

module flash_self_program_control #(
   parameter [31:0] ERASE_CYC = `ERASE_CYC_DFLT,
   parameter [15:0] ENTRY_KEY = `ENTRY_KEY_DFLT
) (
   // Clock and reset.
   input  wire        mclk,
   input  wire        rst_n,
   // AHB-Lite slave.
   input  wire        hsel,
   input  wire [31:0] haddr,
   input  wire [1:0]  htrans,
   input  wire        hwrite,
   input  wire [2:0]  hsize,
   input  wire [31:0] hwdata,
   input  wire        hready,
   output reg         hreadyout,
   output reg         hresp,
   output reg  [31:0] hrdata,
   // JTAG pins of the external programmer.
   input  wire        tck,
   input  wire        tdi,
   input  wire        tms,
   output reg         tdo,
   output reg         tdo_oe_n,
   // Protection state and running code sector.
   input  wire [15:0] sw_prot_off,
   input  wire [15:0] pgm_prot_off,
   input  wire [3:0]  cpu_run_sector,
   // Flash array.
   input  wire        loc_blank,
   input  wire [7:0]  fl_rdata,
   output reg         fl_erase,
   output reg         fl_prog,
   output reg         fl_whole,
   output reg         fl_data_blk,
   output reg  [13:0] fl_addr,
   output reg  [7:0]  fl_wdata,
   // CPU hold.
   output reg         cpu_idle
);

   localparam [15:0] PROG_CYC = `PROG_CYC;

   ////////////////////////////////////////////////////////////////////////
   // Bus address and data phases.
   reg        wr_q;
   reg [9:0]  widx_q;
   wire       acc = hsel & hready & htrans[1];
   wire [9:0] aidx = haddr[11:2];
   wire [7:0] wb = hwdata[7:0];

   reg [7:0]  op_q;
   reg [3:0]  key2_q;
   reg [3:0]  key3_q;
   reg [3:0]  key4_q;
   reg [3:0]  key5_q;
   reg [5:0]  page_q;
   reg [7:0]  offs_q;
   reg [7:0]  pbyte_q;
   reg        dfs_q;
   reg        abort_q;
   reg        refused_q;
   reg        done_q;
   reg        pgm_mode_q;
   reg [2:0]  seq_q;
   reg        rd_pend_q;

   wire [7:0] status = {3'h0, pgm_mode_q, done_q, refused_q, abort_q, fl_erase | fl_prog};

   reg [7:0]  rmux;
   always @* begin
      case (aidx)
         `IDX_OP_SELECT:   rmux = op_q;
         `IDX_KEY_SECOND:  rmux = {4'h0, key2_q};
         `IDX_KEY_THIRD:   rmux = {4'h0, key3_q};
         `IDX_KEY_FOURTH:  rmux = {4'h0, key4_q};
         `IDX_KEY_FIFTH:   rmux = {4'h0, key5_q};
         `IDX_PAGE_SELECT: rmux = {2'h0, page_q};
         `IDX_OFFSET_LOW:  rmux = offs_q;
         `IDX_PROG_BYTE:   rmux = pbyte_q;
         `IDX_ACCESS_CTRL: rmux = {7'h00, dfs_q};
         `IDX_STATUS:      rmux = status;
         default:          rmux = 8'h00;
      endcase
   end

   always @(posedge mclk) begin
      if (!rst_n) begin
         wr_q      <= 1'b0;
         widx_q    <= 10'h000;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
         hrdata    <= 32'h0000_0000;
      end else begin
         wr_q      <= acc & hwrite;
         widx_q    <= aidx;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
         if (acc & ~hwrite)
            hrdata <= {24'h00_0000, rmux};
      end
   end

   wire w_op   = wr_q & (widx_q == `IDX_OP_SELECT);
   wire w_k2   = wr_q & (widx_q == `IDX_KEY_SECOND);
   wire w_k3   = wr_q & (widx_q == `IDX_KEY_THIRD);
   wire w_k4   = wr_q & (widx_q == `IDX_KEY_FOURTH);
   wire w_k5   = wr_q & (widx_q == `IDX_KEY_FIFTH);
   wire w_stat = wr_q & (widx_q == `IDX_STATUS);

   ////////////////////////////////////////////////////////////////////////
   // Unlock sequence and software start check.
   wire op_ok  = (op_q == `OP_SECTOR_ERASE) | (op_q == `OP_BYTE_PROGRAM);
   wire k2_ok  = w_k2 & (wb[3:0] == `KEY_SECOND_VAL) & (seq_q == 3'd1);
   wire k3_ok  = w_k3 & (wb[3:0] == `KEY_THIRD_VAL) & (seq_q == 3'd2);
   wire k4_ok  = w_k4 & (wb[3:0] == `KEY_FOURTH_VAL) & (seq_q == 3'd3);
   wire k5_ok  = w_k5 & (wb[3:0] == `KEY_FIFTH_VAL) & (seq_q == 3'd4);
   wire k_bad  = (w_k2 | w_k3 | w_k4 | w_k5) & ~(k2_ok | k3_ok | k4_ok | k5_ok);
   wire busy   = fl_erase | fl_prog | rd_pend_q;
   wire sw_go  = k5_ok & op_ok;

   wire [3:0] sw_sect = page_q[5:2];
   wire sw_allow = dfs_q | sw_prot_off[sw_sect]
                 | (sw_sect == cpu_run_sector);
   wire sw_is_prog = (op_q == `OP_BYTE_PROGRAM);
   wire sw_ok = sw_go & ~busy & ~pgm_mode_q & sw_allow
              & (~sw_is_prog | loc_blank);
   wire sw_ref = sw_go & ~sw_ok;

   // Address: code uses four sector bits, data block ignores them.
   wire [13:0] sw_addr = dfs_q ? {4'h0, page_q[1:0], offs_q}
                               : {page_q, offs_q};

   always @(posedge mclk) begin
      if (!rst_n) begin
         op_q    <= `REG_RESET;
         page_q  <= 6'h00;
         offs_q  <= `REG_RESET;
         pbyte_q <= `REG_RESET;
         key2_q  <= 4'h0;
         key3_q  <= 4'h0;
         key4_q  <= 4'h0;
         key5_q  <= 4'h0;
         dfs_q   <= 1'b0;
         seq_q   <= 3'd0;
      end else begin
         if (w_op)
            op_q <= wb;
         if (wr_q & (widx_q == `IDX_PAGE_SELECT))
            page_q <= wb[5:0];
         if (wr_q & (widx_q == `IDX_OFFSET_LOW))
            offs_q <= wb;
         if (wr_q & (widx_q == `IDX_PROG_BYTE))
            pbyte_q <= wb;
         if (wr_q & (widx_q == `IDX_ACCESS_CTRL))
            dfs_q <= wb[0];
         if (w_k2)
            key2_q <= wb[3:0];
         if (w_k3)
            key3_q <= wb[3:0];
         if (w_k4)
            key4_q <= wb[3:0];
         if (w_k5)
            key5_q <= wb[3:0];
         if (w_op)
            seq_q <= ((wb == `OP_SECTOR_ERASE) | (wb == `OP_BYTE_PROGRAM)) ? 3'd1 : 3'd0;
         else if (k2_ok | k3_ok | k4_ok)
            seq_q <= seq_q + 3'd1;
         else if (k5_ok | k_bad)
            seq_q <= 3'd0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Programmer pins: synchronisers and edge detect.
   reg [2:0] tck_s;
   reg [1:0] tdi_s;
   reg [1:0] tms_s;
   always @(posedge mclk) begin
      if (!rst_n) begin
         tck_s <= 3'b000;
         tdi_s <= 2'b00;
         tms_s <= 2'b00;
      end else begin
         tck_s <= {tck_s[1:0], tck};
         tdi_s <= {tdi_s[0], tdi};
         tms_s <= {tms_s[0], tms};
      end
   end
   wire tck_rise = tck_s[1] & ~tck_s[2];
   wire tdi_v = tdi_s[1];
   wire tms_v = tms_s[1];

   reg [31:0] frame_q;
   reg [5:0]  fcnt_q;
   reg [7:0]  tdo_sh_q;
   wire frame_rdy = pgm_mode_q & tck_rise & tms_v & (fcnt_q == 6'd31);
   wire [31:0] fr = {frame_q[30:0], tdi_v};
   wire [7:0]  p_cmd = fr[31:24];
   wire        p_dblk = fr[23];
   wire [13:0] p_addr = fr[21:8];
   wire [3:0]  p_sect = p_addr[13:10];
   // Code sector access needs mode 0 protection off; data block does not.
   wire p_allow = p_dblk | pgm_prot_off[p_sect];
   wire p_go = frame_rdy & ~busy;
   wire p_erase = p_go & (p_cmd == `CMD_SECTOR_ERASE) & p_allow;
   wire p_prog  = p_go & (p_cmd == `CMD_BYTE_PROGRAM) & p_allow & loc_blank;
   wire p_read  = p_go & (p_cmd == `CMD_BYTE_READ) & p_allow;
   wire p_chip  = p_go & (p_cmd == `CMD_CHIP_ERASE);
   wire p_blk   = p_go & (p_cmd == `CMD_BLOCK_ERASE);
   wire p_known = (p_cmd == `CMD_SECTOR_ERASE) | (p_cmd == `CMD_BYTE_PROGRAM)
                | (p_cmd == `CMD_BYTE_READ);
   wire p_ref = frame_rdy & ((p_known & ~(p_erase | p_prog | p_read)) | busy);
   wire entry_hit = ~pgm_mode_q & tck_rise & ~tms_v
                  & (fr[15:0] == ENTRY_KEY) & (fcnt_q == 6'd15);

   always @(posedge mclk) begin
      if (!rst_n) begin
         frame_q    <= 32'h0000_0000;
         fcnt_q     <= 6'd0;
         pgm_mode_q <= 1'b0;
         tdo_sh_q   <= 8'h00;
         tdo        <= 1'b0;
         tdo_oe_n   <= 1'b1;
      end else begin
         tdo_oe_n <= ~pgm_mode_q;
         tdo      <= tdo_sh_q[7];
         if (tck_rise) begin
            frame_q <= fr;
            // Entry key is shifted with tms low, frames with tms high.
            if (pgm_mode_q ? ~tms_v : tms_v)
               fcnt_q <= 6'd0;
            else if (pgm_mode_q ? (fcnt_q == 6'd31) : (fcnt_q == 6'd15))
               fcnt_q <= 6'd0;
            else
               fcnt_q <= fcnt_q + 6'd1;
            if (pgm_mode_q & tms_v)
               tdo_sh_q <= {tdo_sh_q[6:0], 1'b0};
         end
         if (entry_hit)
            pgm_mode_q <= 1'b1;
         else if (frame_rdy & (p_cmd == `CMD_EXIT) & ~busy)
            pgm_mode_q <= 1'b0;
         if (rd_pend_q)
            tdo_sh_q <= fl_rdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Operation engine and flash strobes.
   reg [31:0] cnt_q;
   wire start_er = (sw_ok & ~sw_is_prog) | p_erase | p_chip | p_blk;
   wire start_pr = (sw_ok & sw_is_prog) | p_prog;

   always @(posedge mclk) begin
      if (!rst_n) begin
         cnt_q       <= 32'h0000_0000;
         fl_erase    <= 1'b0;
         fl_prog     <= 1'b0;
         fl_whole    <= 1'b0;
         fl_data_blk <= 1'b0;
         fl_addr     <= 14'h0000;
         fl_wdata    <= 8'h00;
         cpu_idle    <= 1'b0;
         rd_pend_q   <= 1'b0;
         abort_q     <= 1'b0;
         refused_q   <= 1'b0;
         done_q      <= 1'b0;
      end else begin
         rd_pend_q <= p_read;
         if (p_read) begin
            fl_addr     <= p_addr;
            fl_data_blk <= p_dblk;
         end
         if (start_er | start_pr) begin
            fl_erase    <= start_er;
            fl_prog     <= start_pr;
            fl_whole    <= p_chip | p_blk;
            fl_data_blk <= sw_ok ? dfs_q : (p_dblk | p_blk) & ~p_chip;
            fl_addr     <= sw_ok ? sw_addr : p_addr;
            fl_wdata    <= sw_ok ? pbyte_q : fr[7:0];
            cpu_idle    <= sw_ok;
            cnt_q       <= start_er ? ERASE_CYC - 32'd1 : {16'h0000, PROG_CYC} - 32'd1;
         end else if (fl_erase | fl_prog) begin
            if (cnt_q == 32'h0000_0000) begin
               fl_erase <= 1'b0;
               fl_prog  <= 1'b0;
               fl_whole <= 1'b0;
               cpu_idle <= 1'b0;
            end else begin
               cnt_q <= cnt_q - 32'd1;
            end
         end
         // Sticky flags: a new event wins over a clear in the same cycle.
         if (k_bad | (w_op & ~((wb == `OP_SECTOR_ERASE) | (wb == `OP_BYTE_PROGRAM))))
            abort_q <= 1'b1;
         else if (w_stat & wb[`ST_ABORT])
            abort_q <= 1'b0;
         if (sw_ref | p_ref)
            refused_q <= 1'b1;
         else if (w_stat & wb[`ST_REFUSED])
            refused_q <= 1'b0;
         if ((fl_erase | fl_prog) & (cnt_q == 32'h0000_0000) & ~(start_er | start_pr))
            done_q <= 1'b1;
         else if (w_stat & wb[`ST_DONE])
            done_q <= 1'b0;
      end
   end

   // hsize is a whole word on this bus; no lane selection is needed.
   wire unused_ok = &{1'b0, hsize, haddr[31:12], haddr[1:0], hwdata[31:8], htrans[0]};

endmodule // flash_self_program_control
`default_nettype wire

/* File: flash_prog_assertions.sv */
// Checker on the ports of the flash programming controller.
`default_nettype none
module flash_prog_assertions #(parameter [31:0] ERASE_CYC = 32'd20) (
   // Clock, reset and mode.
   input wire logic        mclk, rst_n, tdo_oe_n, loc_blank, cpu_idle,
   // Flash array side.
   input wire logic        fl_erase, fl_prog, fl_whole, fl_data_blk,
   input wire logic [13:0] fl_addr,
   input wire logic [7:0]  fl_wdata,
   // Protection.
   input wire logic [15:0] sw_prot_off, pgm_prot_off,
   input wire logic [3:0]  cpu_run_sector
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [31:0] ecnt_q;
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);
   sequence s_start;
      $rose(fl_erase) || $rose(fl_prog);
   endsequence
   sequence s_prog_run;
      fl_prog [*8];
   endsequence
   // Counts the cycles of one erase.
   always_ff @(posedge mclk) begin
      if (!rst_n || !fl_erase)
         ecnt_q <= 32'h0;
      else
         ecnt_q <= ecnt_q + 32'h1;
   end
   AST_ONE_OP: assert property (!(fl_erase && fl_prog))
      else $error("erase and program overlap");
   AST_ERASE_TIME: assert property (fl_erase |-> ecnt_q < ERASE_CYC)
      else $error("erase too long");
   AST_PROG_TIME: assert property ($rose(fl_prog) |-> s_prog_run ##[1:743] !fl_prog)
      else $error("program time wrong");
   AST_CPU_HOLD: assert property (cpu_idle == ((fl_erase || fl_prog) && tdo_oe_n))
      else $error("cpu hold wrong");
   AST_WHOLE_ICP: assert property (fl_whole |-> fl_erase && !tdo_oe_n)
      else $error("whole erase outside programmer mode");
   AST_SW_PROT: assert property (s_start ##0 (cpu_idle && !fl_data_blk) |->
      sw_prot_off[fl_addr[13:10]] || cpu_run_sector == fl_addr[13:10])
      else $error("software reached protected sector");
   AST_ICP_PROT: assert property (s_start ##0 (!tdo_oe_n && !fl_whole && !fl_data_blk) |->
      pgm_prot_off[fl_addr[13:10]])
      else $error("programmer reached protected sector");
   AST_BLANK: assert property ($rose(fl_prog) |-> $past(loc_blank))
      else $error("program of a written location");
   AST_OP_HOLD: assert property (fl_prog && $past(fl_prog) |->
      $stable(fl_addr) && $stable(fl_wdata))
      else $error("address or data moved");
endmodule // flash_prog_assertions
`default_nettype wire

/* File: jtag_prog_model.sv */
// Behavioural external programmer driving the tck, tdi and tms pins.
`default_nettype none
module jtag_prog_model (
   input  wire logic mclk,
   output var  logic tck,
   output var  logic tdi,
   output var  logic tms
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      tck = 1'b0;
      tdi = 1'b0;
      tms = 1'b0;
   end
   // Shifts nb bits msb first; tck stands low between bursts.
   task automatic shift(input logic [31:0] v, input int nb, input logic m);
      for (int i = nb - 1; i >= 0; i--) begin
         tms <= m;
         tdi <= v[i];
         repeat (4) @(posedge mclk);
         tck <= 1'b1;
         repeat (4) @(posedge mclk);
         tck <= 1'b0;
      end
      repeat (4) @(posedge mclk);
      tms <= 1'b0;
      tdi <= ~tdi;
   endtask
endmodule // jtag_prog_model
`default_nettype wire

/* File: flash_self_program_control_tb.sv */
// Self-checking bench of the flash programming controller.
`include "flash_prog_consts.vh"
`default_nettype none
module flash_self_program_control_tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam [15:0] KEY = `ENTRY_KEY_DFLT;
   logic        mclk, rst_n, hsel, hwrite, hreadyout, hresp, tck, tdi, tms, tdo, tdo_oe_n;
   logic        loc_blank, fl_erase, fl_prog, fl_whole, fl_data_blk, cpu_idle;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic [3:0]  cpu_run_sector;
   logic [7:0]  fl_rdata, fl_wdata, rd, o, d;
   logic [13:0] fl_addr;
   logic [15:0] sw_prot_off, pgm_prot_off;
   logic [31:0] haddr, hwdata, hrdata, seed;
   logic [7:0]  mdl [bit [9:0]];
   int          miscompares, n_compared;
   flash_self_program_control #(.ERASE_CYC(32'd20), .ENTRY_KEY(KEY))
      i_flash_self_program_control (.*, .hready(hreadyout));
   jtag_prog_model i_jtag_prog_model (.*);
   initial begin
      mclk = 1'b0;
      forever #20 mclk = ~mclk;
   end
   always @(posedge mclk) fl_rdata <= d;
   task automatic end_sim;
      $display("compared %0d miscompares %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task automatic hang;
      miscompares++;
      $display("[FAIL] %0t wait bound used up", $time);
      end_sim();
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
      n_compared++;
      if (g !== e) begin
         miscompares++;
         $display("[FAIL] %0t %s got %h exp %h", $time, m, g, e);
      end
   endtask
   task automatic bus(input logic w, input logic [9:0] i, input logic [7:0] v);
      int n;
      n = 0;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= {20'h0, i, 2'h0};
      do begin
         @(posedge mclk);
         n++;
      end while (hreadyout !== 1'b1 && n < 20);
      htrans <= 2'h0;
      hwdata <= {24'h0, v};
      do begin
         @(posedge mclk);
         n++;
      end while (hreadyout !== 1'b1 && n < 20);
      rd = hrdata[7:0];
      if (n >= 20)
         hang();
      if (mdl.exists(i) && w)
         mdl[i] = v;
      else if (mdl.exists(i))
         chk(hrdata, {24'h0, mdl[i]}, "register");
   endtask
   task automatic setup(input logic [7:0] p);
      o = 8'($random(seed));
      d = 8'($random(seed));
      bus(1'b1, `IDX_PAGE_SELECT, p);
      bus(1'b1, `IDX_OFFSET_LOW, o);
      bus(1'b1, `IDX_PROG_BYTE, d);
   endtask
   task automatic sw_op(input logic [7:0] op, input int bad);
      logic [3:0] k [4];
      k = '{`KEY_SECOND_VAL, `KEY_THIRD_VAL, `KEY_FOURTH_VAL, `KEY_FIFTH_VAL};
      bus(1'b1, `IDX_OP_SELECT, op);
      for (int i = 0; i < 4; i++)
         bus(1'b1, `IDX_KEY_SECOND + 10'(i), {4'h0, k[i] ^ ((i == bad) ? 4'hF : 4'h0)});
   endtask
   task automatic op_chk(input logic [1:0] e, input logic [13:0] a, input logic [13:0] m,
                         input logic [2:0] f);
      int n;
      n = 0;
      while (fl_erase !== 1'b1 && fl_prog !== 1'b1 && n < 40) begin
         @(posedge mclk);
         n++;
      end
      chk({fl_erase, fl_prog}, e, "strobes");
      if (e != 2'b00) begin
         chk(fl_addr & m, a, "address");
         chk({fl_whole, fl_data_blk, cpu_idle}, f, "target");
         if (e == 2'b01)
            chk(fl_wdata, d, "data");
         while ((fl_erase || fl_prog) && n < 900) begin
            @(posedge mclk);
            n++;
         end
         if (n >= 900)
            hang();
      end
   endtask
   task automatic stat(input logic [4:0] e, input logic [4:0] m);
      bus(1'b0, `IDX_STATUS, 8'h00);
      chk(rd[4:0] & m, e, "status");
      bus(1'b1, `IDX_STATUS, 8'h0E);
   endtask
   task automatic frame(input logic [7:0] c, input logic b, input logic [13:0] a);
      i_jtag_prog_model.shift({c, b, 1'b0, a, d}, 32, 1'b1);
   endtask
   initial begin
      seed = 32'hA5509D4B;
      {rst_n, hwrite, htrans, haddr, hwdata} = '0;
      hsize = 3'h2;
      hsel = 1'b1;
      loc_blank = 1'b1;
      fl_rdata = 8'h00;
      sw_prot_off = 16'h0020;
      pgm_prot_off = 16'h0000;
      cpu_run_sector = 4'h0;
      mdl[`IDX_PAGE_SELECT] = 8'h00;
      mdl[`IDX_OFFSET_LOW] = 8'h00;
      mdl[`IDX_PROG_BYTE] = 8'h00;
      repeat (6) @(posedge mclk);
      rst_n <= 1'b1;
      bus(1'b0, `IDX_OP_SELECT, 8'h00);
      chk(rd, 8'h00, "op select reset");
      bus(1'b1, 10'h010, 8'hFF);
      bus(1'b0, 10'h010, 8'h00);
      chk(hrdata, 32'h0, "unmapped");
      repeat (4) begin
         foreach (mdl[i])
            bus(1'b0, i, 8'h00);
         setup(8'($random(seed)) & 8'h3F);
      end
      setup(8'h16);
      sw_op(`OP_BYTE_PROGRAM, 9);
      op_chk(2'b01, {6'h16, o}, 14'h3FFF, 3'b001);
      stat(5'h08, 5'h1F);
      sw_op(`OP_SECTOR_ERASE, 9);
      op_chk(2'b10, 14'h1400, 14'h3C00, 3'b001);
      stat(5'h08, 5'h1F);
      setup(8'h18);
      sw_op(`OP_BYTE_PROGRAM, 9);
      op_chk(2'b00, 14'h0, 14'h0, 3'b000);
      stat(5'h04, 5'h1F);
      cpu_run_sector <= 4'h6;
      sw_op(`OP_BYTE_PROGRAM, 9);
      op_chk(2'b01, {6'h18, o}, 14'h3FFF, 3'b001);
      stat(5'h08, 5'h1F);
      cpu_run_sector <= 4'h0;
      loc_blank <= 1'b0;
      setup(8'h16);
      sw_op(`OP_BYTE_PROGRAM, 9);
      op_chk(2'b00, 14'h0, 14'h0, 3'b000);
      stat(5'h04, 5'h1F);
      loc_blank <= 1'b1;
      for (int b = 0; b < 4; b++) begin
         sw_op(`OP_SECTOR_ERASE, b);
         op_chk(2'b00, 14'h0, 14'h0, 3'b000);
         stat(5'h02, 5'h1F);
      end
      bus(1'b1, `IDX_ACCESS_CTRL, 8'h01);
      setup(8'h3E);
      sw_op(`OP_BYTE_PROGRAM, 9);
      op_chk(2'b01, {6'h02, o}, 14'h03FF, 3'b011);
      stat(5'h08, 5'h1F);
      sw_op(`OP_SECTOR_ERASE, 9);
      op_chk(2'b10, 14'h0200, 14'h0300, 3'b011);
      stat(5'h08, 5'h1F);
      bus(1'b1, `IDX_ACCESS_CTRL, 8'h00);
      i_jtag_prog_model.shift({16'h0, ~KEY}, 16, 1'b0);
      stat(5'h00, 5'h10);
      i_jtag_prog_model.shift({16'h0, KEY}, 16, 1'b0);
      stat(5'h10, 5'h10);
      chk(tdo_oe_n, 1'b0, "tdo drive");
      frame(`CMD_CHIP_ERASE, 1'b0, 14'h0);
      op_chk(2'b10, 14'h0, 14'h0, 3'b100);
      frame(`CMD_SECTOR_ERASE, 1'b0, 14'h0C00);
      op_chk(2'b00, 14'h0, 14'h0, 3'b000);
      stat(5'h04, 5'h04);
      pgm_prot_off <= 16'h0008;
      d = 8'($random(seed));
      frame(`CMD_BYTE_PROGRAM, 1'b0, 14'h0C55);
      op_chk(2'b01, 14'h0C55, 14'h3FFF, 3'b000);
      frame(`CMD_BLOCK_ERASE, 1'b1, 14'h0);
      op_chk(2'b10, 14'h0, 14'h0, 3'b110);
      d = 8'($random(seed));
      frame(`CMD_BYTE_READ, 1'b0, 14'h0C00);
      repeat (2) @(posedge mclk);
      chk(tdo, d[7], "read byte msb");
      pgm_prot_off <= 16'h0000;
      frame(`CMD_BYTE_READ, 1'b0, 14'h0C00);
      stat(5'h04, 5'h04);
      frame(`CMD_EXIT, 1'b0, 14'h0);
      stat(5'h00, 5'h10);
      end_sim();
   end
endmodule // flash_self_program_control_tb
bind flash_self_program_control flash_prog_assertions #(.ERASE_CYC(ERASE_CYC))
   i_flash_prog_assertions (.*);
`default_nettype wire
